// ===== sar_adc_control.sv
// sar_adc_control.sv: converter control with avalon register slave
// assumes: analog front end answers comparator in the same bit period
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sar_adc_map.svh"
module sar_adc_control (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic [3:0]             address_i,
   input  wire logic                   read_i,
   input  wire logic                   write_i,
   input  wire logic [31:0]            writedata_i,
   input  wire logic [3:0]             byteenable_i,
   output logic [31:0]                 readdata_o,
   output logic                        waitrequest_o,
   input  wire logic                   sleep_i,
   input  wire logic                   rc_tick_i,
   input  wire logic                   comp_high_i,
   input  wire logic                   irq_flag_clear_i,
   output logic                        conversion_done_irq_flag_o,
   output sar_adc_pkg::front_end_type  front_end_o,
   output logic [4:0]                  pin_analog_o
);

   ////////////////////////////////////////////////////////////////////////
   // registers and state
   logic [7:0]             ctl_q;
   logic [7:0]             pcf_q;
   logic [9:0]             result_q;
   logic                   flag_q;
   logic [31:0]            rdata_q;
   logic                   ack_q;
   sar_adc_pkg::phase_type phase_q;
   logic [2:0]             div_q;
   logic [3:0]             per_q;
   logic                   rc_s1_q;
   logic                   rc_s2_q;
   logic                   rc_s3_q;
   logic                   wait_q;
   sar_adc_pkg::front_end_type fe_q;
   logic [4:0]             pin_q;

   logic [9:0]             trial;
   logic                   sar_done;

   ////////////////////////////////////////////////////////////////////////
   // decoding
   function automatic logic [4:0] onehot_channel(input logic [2:0] code);
      onehot_channel = (code <= `CH_LAST) ? (5'h01 << code) : 5'h00;
   endfunction : onehot_channel

   // pin map: {high ref pin used, low ref pin used, analog mask}
   function automatic logic [6:0] pin_map(input logic [3:0] cfg);
      case (cfg)
         4'h0, 4'h2, 4'h9: pin_map = 7'h1F;
         4'h1, 4'h3, 4'hA: pin_map = 7'h57;
         4'h4:             pin_map = 7'h0B;
         4'h5:             pin_map = 7'h43;
         4'h6, 4'h7:       pin_map = 7'h00;
         4'h8, 4'hB, 4'hC: pin_map = 7'h73;
         4'hD:             pin_map = 7'h63;
         4'hE:             pin_map = 7'h01;
         default:          pin_map = 7'h61;
      endcase
   endfunction : pin_map

   wire        req        = read_i | write_i;
   wire        sel_ctl    = (address_i == `ADDR_CONTROL);
   wire        sel_pcf    = (address_i == `ADDR_PIN_CONFIG);
   wire        sel_hi     = (address_i == `ADDR_RESULT_HIGH);
   wire        sel_lo     = (address_i == `ADDR_RESULT_LOW);
   wire        take       = req & ~ack_q;
   wire        wr_ctl     = take & write_i & sel_ctl & byteenable_i[0];
   wire        wr_pcf     = take & write_i & sel_pcf & byteenable_i[0];
   wire [1:0]  clk_sel    = ctl_q[`CTL_CLK_HI:`CTL_CLK_LO];
   wire [2:0]  ch_sel     = ctl_q[`CTL_CH_HI:`CTL_CH_LO];
   wire        powered    = ctl_q[`CTL_POWER];
   wire        go_bit     = ctl_q[`CTL_GO];
   wire        use_rc     = (clk_sel == `CLK_RC);
   wire        rc_edge    = rc_s2_q & ~rc_s3_q;
   wire        halted     = sleep_i & ~use_rc;
   wire [2:0]  div_last   = (clk_sel == `CLK_DIV8) ? `DIV8_LAST
                          : use_rc ? `RC_DIV_LAST : `DIV2_LAST;
   wire        div_step   = use_rc ? rc_edge : 1'b1;
   wire        conv_bit_period        = powered & ~halted & div_step
                          & (div_q == div_last);
   wire        per_end    = conv_bit_period & (per_q == 4'h1);
   wire        acquiring  = (phase_q == sar_adc_pkg::st_acquire);
   wire        converting = (phase_q == sar_adc_pkg::st_convert);
   wire        conv_start = acquiring & per_end;
   wire        sar_step   = converting & conv_bit_period;
   wire        complete   = converting & sar_done;
   wire [6:0]  pmap       = pin_map(pcf_q[3:0]);
   wire        justify    = pcf_q[`PCF_JUSTIFY];
   // right or left justified result bytes
   wire [7:0]  res_hi     = justify ? {6'h00, result_q[9:8]}
                                    : result_q[9:2];
   wire [7:0]  res_lo     = justify ? result_q[7:0]
                                    : {result_q[1:0], 6'h00};
   // exactly four registers, unmapped reads zero
   wire [7:0]  rsel       = sel_hi  ? res_hi
                          : sel_lo  ? res_lo
                          : sel_ctl ? (ctl_q & `CTL_WMASK)
                          : sel_pcf ? (pcf_q & `PCF_WMASK)
                          : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // approximation register; the comparator answers our own registered
   // trial code on this clock, so a synchroniser would cost a bit period
   sar_adc_approx approx_u (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .start_i     (conv_start),
      .step_i      (sar_step),
      .comp_high_i (comp_high_i),
      .trial_o     (trial),
      .done_o      (sar_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // rc oscillator pin: two flops, then a third for edge detection
   always_ff @(posedge clk_i) begin
      rc_s1_q  <= rc_tick_i;
      rc_s2_q  <= rc_s1_q;
      rc_s3_q  <= rc_s2_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q   <= take;
         wait_q  <= ~take;
         if (take & read_i) rdata_q <= {24'h00_0000, rsel};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register: hardware clear of go at completion wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q <= `CTL_RESET;
      end else begin
         if (wr_ctl) ctl_q <= writedata_i[7:0] & `CTL_WMASK;
         if (complete | (wr_ctl & ~writedata_i[`CTL_POWER]))
            ctl_q[`CTL_GO] <= 1'b0;
      end
   end

   // pin configuration register
   always_ff @(posedge clk_i) begin
      if (rst_i) pcf_q <= `PCF_RESET;
      else if (wr_pcf) pcf_q <= writedata_i[7:0] & `PCF_WMASK;
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion clock divider and phase counter
   always_ff @(posedge clk_i) begin
      if (rst_i | ~powered) div_q <= 3'h0;
      else if (~halted & div_step)
         div_q <= (div_q == div_last) ? 3'h0 : div_q + 3'h1;
   end

   // sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= sar_adc_pkg::st_off;
         per_q   <= 4'h0;
      end else if (~powered) begin
         phase_q <= sar_adc_pkg::st_off;
         per_q   <= 4'h0;
      end else begin
         case (phase_q)
            sar_adc_pkg::st_off: phase_q <= sar_adc_pkg::st_idle;
            sar_adc_pkg::st_idle: if (go_bit) begin
               phase_q <= sar_adc_pkg::st_acquire;
               per_q   <= `ACQ_PERIODS;
            end
            sar_adc_pkg::st_acquire: if (conv_bit_period) begin
               if (per_end) phase_q <= sar_adc_pkg::st_convert;
               else per_q <= per_q - 4'h1;
            end
            sar_adc_pkg::st_convert: if (complete) begin
               phase_q <= sar_adc_pkg::st_gap;
               per_q   <= `GAP_PERIODS;
            end
            sar_adc_pkg::st_gap: if (conv_bit_period) begin
               if (per_end) phase_q <= sar_adc_pkg::st_idle;
               else per_q <= per_q - 4'h1;
            end
            default: phase_q <= sar_adc_pkg::st_off;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result and completion flag: set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= 10'h000;
         flag_q   <= 1'b0;
      end else begin
         if (complete) result_q <= trial;
         if (complete) flag_q <= 1'b1;
         else if (irq_flag_clear_i) flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // front end drive, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fe_q  <= '0;
         pin_q <= 5'h00;
      end else begin
         fe_q.power          <= powered;
         fe_q.sample         <= acquiring;
         fe_q.channel_onehot <= acquiring
                              ? onehot_channel(ch_sel)
                                & pmap[4:0] : 5'h00;
         // comparator enabled for the whole conversion, not per step
         fe_q.compare_valid  <= converting;
         fe_q.trial_code     <= trial;
         fe_q.high_ref_sel   <= pmap[6] ? 2'h1 : 2'h0;
         fe_q.low_ref_sel    <= pmap[5] ? 2'h1 : 2'h0;
         pin_q               <= pmap[4:0];
      end
   end

   assign readdata_o                 = rdata_q;
   assign waitrequest_o              = wait_q;
   assign conversion_done_irq_flag_o = flag_q;
   assign front_end_o                = fe_q;
   assign pin_analog_o               = pin_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking chk_clk @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_done;
      complete;
   endsequence

   // bus answer: one low cycle of waitrequest, then high again
   sequence s_answer;
      !waitrequest_o ##1 waitrequest_o;
   endsequence

   chk_done_loads_flag: assert property (
      s_done |=> flag_q && !go_bit && result_q == $past(trial))
      else $error("completion did not load result and flag");

   chk_one_channel: assert property (
      $onehot0(fe_q.channel_onehot))
      else $error("more than one channel routed");

   chk_hold_convert: assert property (
      converting |=> !fe_q.sample)
      else $error("sampling during conversion");

   chk_gap_no_sample: assert property (
      s_done |=> phase_q == sar_adc_pkg::st_gap
                 ##1 fe_q.channel_onehot == 5'h00)
      else $error("input connected during gap");

   // a halted divider must not advance, whatever tad decodes
   chk_sleep_halt: assert property (
      sleep_i && !use_rc && powered |=> $stable(div_q))
      else $error("conversion clock ran in sleep");

   chk_bit1_zero: assert property (
      ack_q && sel_ctl && read_i |-> readdata_o[1] == 1'b0)
      else $error("control bit 1 read nonzero");

   chk_off_idle: assert property (
      !powered |=> phase_q == sar_adc_pkg::st_off)
      else $error("converter ran while off");

   chk_unused_code: assert property (
      ch_sel > `CH_LAST |=> fe_q.channel_onehot == 5'h00)
      else $error("unused channel code routed");

   chk_justify_hi: assert property (
      justify |-> res_hi[7:2] == 6'h00)
      else $error("right justified high byte not zero");

   chk_bus_answer: assert property (
      take |=> s_answer)
      else $error("register access not answered in one cycle");

   chk_compare_level: assert property (
      converting |=> fe_q.compare_valid)
      else $error("comparator not enabled during conversion");

endmodule : sar_adc_control

// ===== sar_adc_map.svh
// sar_adc_map.svh: register offsets, field positions, reset values, timing
// assumes: included by bare name from the package and the design modules
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// register byte addresses on the avalon word bus
`define ADDR_RESULT_HIGH  4'h0
`define ADDR_RESULT_LOW   4'h4
`define ADDR_CONTROL      4'h8
`define ADDR_PIN_CONFIG   4'hC

// control register fields
`define CTL_CLK_HI        7
`define CTL_CLK_LO        6
`define CTL_CH_HI         5
`define CTL_CH_LO         3
`define CTL_GO            2
`define CTL_POWER         0
`define CTL_WMASK         8'hFD
`define CTL_RESET         8'h00

// pin configuration register fields
`define PCF_JUSTIFY       7
`define PCF_WMASK         8'h8F
`define PCF_RESET         8'h00

// clock select codes and channel limit
`define CLK_DIV2          2'h0
`define CLK_DIV8          2'h1
`define CLK_RC            2'h3
`define CH_LAST           3'h4

// conversion clock divider terminal counts (bit period less one)
`define DIV2_LAST         3'h1
`define DIV8_LAST         3'h7
`define RC_DIV_LAST       3'h3

// bit periods spent per phase
`define ACQ_PERIODS       4'h2
`define GAP_PERIODS       4'h2
`define RESULT_BITS       4'hA

`endif

// ===== sar_adc_pkg.sv
// sar_adc_pkg.sv: types shared by the converter control design
// assumes: nothing beyond the map header
`include "sar_adc_map.svh"
package sar_adc_pkg;

   typedef enum logic [2:0] {
      st_off,
      st_idle,
      st_acquire,
      st_convert,
      st_gap
   } phase_type;

   // analog front end controls
   typedef struct packed {
      logic       power;
      logic       sample;
      logic [4:0] channel_onehot;
      logic       compare_valid;
      logic [9:0] trial_code;
      logic [1:0] high_ref_sel;
      logic [1:0] low_ref_sel;
   } front_end_type;

endpackage : sar_adc_pkg

// ===== sar_adc_approx.sv
// sar_adc_approx.sv: ten-bit successive approximation register
// assumes: step pulses come once per bit period from the parent
`timescale 1ns/1ps
`include "sar_adc_map.svh"
module sar_adc_approx (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic       step_i,
   input  wire logic       comp_high_i,
   output logic [9:0]      trial_o,
   output logic            done_o
);

   logic [9:0] trial_q;
   logic [9:0] mask_q;
   logic       done_q;

   // keep or drop the trial bit, then try the next lower one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trial_q <= 10'h000;
         mask_q  <= 10'h000;
         done_q  <= 1'b0;
      end else if (start_i) begin
         trial_q <= 10'h200;
         mask_q  <= 10'h200;
         done_q  <= 1'b0;
      end else if (step_i && (mask_q != 10'h000)) begin
         trial_q <= (comp_high_i ? trial_q : (trial_q & ~mask_q))
                    | (mask_q >> 1);
         mask_q  <= mask_q >> 1;
         done_q  <= (mask_q == 10'h001);
      end else begin
         done_q  <= 1'b0;
      end
   end

   assign trial_o = trial_q;
   assign done_o  = done_q;

endmodule : sar_adc_approx

// ===== sar_adc_front_model.sv
// sar_adc_front_model.sv: sample-and-hold and comparator behaviour
// assumes: fed by the control block front end outputs on the same clock
`timescale 1ns/1ps
module sar_adc_front_model (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire sar_adc_pkg::front_end_type  front_end_i,
   input  wire logic [49:0]                 levels_i,
   output logic                             comp_high_o
);
   logic [9:0] live;
   logic [9:0] held_q;
   logic       idle_q;

   ////////////////////////////////////////////////////////////////////////
   // two routed inputs would mix, so a bad select shows in the result
   always_comb begin
      live = 10'h000;
      for (int i = 0; i < 5; i++) begin
         if (front_end_i.channel_onehot[i]) begin
            live = live | levels_i[i*10 +: 10];
         end
      end
   end

   // capacitor charges only while sampling; disconnected otherwise
   always_ff @(posedge clk_i) begin
      idle_q <= rst_i ? 1'b0 : ~idle_q;
      if (rst_i) begin
         held_q <= 10'h000;
      end else if (front_end_i.power && front_end_i.sample) begin
         held_q <= live;
      end
   end

   // comparator is meaningless outside conversion: it wanders
   assign comp_high_o = (front_end_i.power && front_end_i.compare_valid) ?
                        (held_q >= front_end_i.trial_code) : idle_q;
endmodule : sar_adc_front_model

// ===== sar_adc_control_tb.sv
// sar_adc_control_tb.sv: self-checking bench for the converter control
// assumes: design files and front end model compiled before this file
`timescale 1ns/1ps
`include "sar_adc_map.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   num_errors++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module sar_adc_control_tb;
   localparam logic [4:0] MASK_TAB [16] = '{5'h1F, 5'h17, 5'h1F, 5'h17,
      5'h0B, 5'h03, 5'h00, 5'h00, 5'h13, 5'h1F, 5'h17, 5'h13, 5'h13,
      5'h03, 5'h01, 5'h01};
   localparam logic [15:0] HREF = 16'hBD2A;
   localparam logic [15:0] LREF = 16'hB900;
   logic clk_i, rst_i, read_i, write_i, waitrequest_o, sleep_i, rc_tick_i;
   logic comp_high_i, irq_flag_clear_i, conversion_done_irq_flag_o;
   logic [3:0]  address_i, byteenable_i;
   logic [31:0] writedata_i, readdata_o;
   logic [4:0]  pin_analog_o;
   logic [49:0] levels_i;
   sar_adc_pkg::front_end_type front_end_o;
   logic [7:0] q;
   logic [1:0] prev_code;
   logic [4:0] want_ch;
   logic       flag_prev, samp_prev;
   int num_errors, compares, cyc, rc_div, since_done, gap_min;

   sar_adc_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .address_i(address_i), .read_i(read_i), .write_i(write_i),
      .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .sleep_i(sleep_i), .rc_tick_i(rc_tick_i), .comp_high_i(comp_high_i),
      .irq_flag_clear_i(irq_flag_clear_i),
      .conversion_done_irq_flag_o(conversion_done_irq_flag_o),
      .front_end_o(front_end_o), .pin_analog_o(pin_analog_o));
   sar_adc_front_model model_u (.clk_i(clk_i), .rst_i(rst_i),
      .front_end_i(front_end_o), .levels_i(levels_i),
      .comp_high_o(comp_high_i));

   ////////////////////////////////////////////////////////////////////////
   // clock, slow rc oscillator and run limit
   initial clk_i = 1'b0;
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      rc_div <= (rc_div == 2) ? 0 : rc_div + 1;
      if (rc_div == 2) rc_tick_i <= ~rc_tick_i;
      if (cyc == 60000) begin
         num_errors++;
         finish_test();
      end
   end

   // routing while sampling, and idle time after a completion when the clock code repeats and is not rc
   always @(posedge clk_i) begin
      since_done <= since_done + 1;
      if (conversion_done_irq_flag_o === 1'b1 && flag_prev !== 1'b1)
         since_done <= 1;
      flag_prev <= conversion_done_irq_flag_o;
      samp_prev <= front_end_o.sample;
      if (front_end_o.sample === 1'b1) begin
         `CHK("channel", want_ch, front_end_o.channel_onehot)
         if (samp_prev !== 1'b1 && gap_min > 0)
            `CHK("gap", 1'b1, since_done >= gap_min)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic int bp(input logic [1:0] c);
      return (c == 2'h1) ? 8 : (c == 2'h3) ? 0 : 2;
   endfunction : bp

   // one avalon cycle: hold until waitrequest low, then release
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] r);
      address_i <= a;
      write_i <= w;
      read_i <= ~w;
      writedata_i <= {24'h00_0000, d};
      byteenable_i <= 4'hF;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0) @(posedge clk_i);
      r = readdata_o[7:0];
      write_i <= 1'b0;
      read_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   // full conversion with result, flag and justification checks
   task automatic convert(input logic [1:0] code, input logic [2:0] ch,
                          input logic [7:0] pcfg, input logic stall);
      logic [9:0] v;
      logic [7:0] eh, el;
      int n;
      bus(`ADDR_PIN_CONFIG, 1'b1, pcfg, q);
      `CHK("pins", MASK_TAB[pcfg[3:0]], pin_analog_o)
      // a channel whose pin is digital is not routed and converts zero
      want_ch = (5'h01 << ch) & MASK_TAB[pcfg[3:0]];
      v = want_ch[ch] ? levels_i[ch*10 +: 10] : 10'h000;
      gap_min = (code == prev_code) ? 2 * bp(code) : 0;
      prev_code = code;
      sleep_i <= stall | (code == 2'h3 && $urandom_range(1) == 1);
      bus(`ADDR_CONTROL, 1'b1, {code, ch, 3'b101}, q);
      if (stall) begin
         repeat (100) @(posedge clk_i);
         bus(`ADDR_CONTROL, 1'b0, 8'h00, q);
         `CHK("sleep hold", {code, ch, 3'b101}, q)
         sleep_i <= 1'b0;
      end
      n = 0;
      do begin
         bus(`ADDR_CONTROL, 1'b0, 8'h00, q);
         n++;
         if (front_end_o.compare_valid === 1'b1) begin
            `CHK("href", {1'b0, HREF[pcfg[3:0]]}, front_end_o.high_ref_sel)
            `CHK("lref", {1'b0, LREF[pcfg[3:0]]}, front_end_o.low_ref_sel)
            levels_i <= ~levels_i;
         end
      end while (q[`CTL_GO] !== 1'b0 && n < 2000);
      `CHK("done ctl", {code, ch, 3'b001}, q)
      `CHK("flag", 1'b1, conversion_done_irq_flag_o)
      eh = pcfg[7] ? {6'h00, v[9:8]} : v[9:2];
      el = pcfg[7] ? v[7:0] : {v[1:0], 6'h00};
      bus(`ADDR_RESULT_HIGH, 1'b0, 8'h00, q);
      `CHK("res high", eh, q)
      bus(`ADDR_RESULT_LOW, 1'b0, 8'h00, q);
      `CHK("res low", el, q)
      irq_flag_clear_i <= 1'b1;
      @(posedge clk_i);
      irq_flag_clear_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("flag clr", 1'b0, conversion_done_irq_flag_o)
   endtask : convert

   task automatic finish_test;
      if (num_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////
   // reset, register map, abort, then random conversions
   initial begin
      {rst_i, read_i, write_i, sleep_i, rc_tick_i, irq_flag_clear_i} = 6'h20;
      {address_i, byteenable_i, writedata_i, levels_i} = '0;
      {num_errors, compares, cyc, rc_div, gap_min} = '0;
      since_done = 1000;
      prev_code = 2'h3;
      want_ch = 5'h00; // abort uses channel 1, digital under pin code f
      void'($urandom(29));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 16; a += 4) begin
         bus(4'(a), 1'b0, 8'h00, q);
         `CHK("reset", 8'h00, q)
      end
      bus(4'h2, 1'b1, 8'hFF, q);
      bus(4'h2, 1'b0, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      bus(`ADDR_CONTROL, 1'b1, 8'hFA, q);
      bus(`ADDR_CONTROL, 1'b0, 8'h00, q);
      `CHK("ctl bits", 8'hF8, q)
      bus(`ADDR_PIN_CONFIG, 1'b1, 8'hFF, q);
      bus(`ADDR_PIN_CONFIG, 1'b0, 8'h00, q);
      `CHK("pcf bits", 8'h8F, q)
      bus(`ADDR_CONTROL, 1'b1, 8'h4D, q);
      repeat (20) @(posedge clk_i);
      bus(`ADDR_CONTROL, 1'b1, 8'h48, q);
      bus(`ADDR_CONTROL, 1'b0, 8'h00, q);
      `CHK("abort ctl", 8'h48, q)
      `CHK("abort pwr", 1'b0, front_end_o.power)
      `CHK("abort flag", 1'b0, conversion_done_irq_flag_o)
      for (int i = 0; i < 14; i++) begin
         levels_i <= (i == 1) ? '1 : (i == 2) ? '0 :
                     50'({$urandom, $urandom});
         convert((i < 4) ? 2'(i) : 2'($urandom_range(3)),
                 3'($urandom_range(4)), 8'($urandom), i == 0);
      end
      finish_test();
   end
endmodule : sar_adc_control_tb
